// [inc/rfs_pkg.sv]
// package: register map, field layout, resets and encodings of the receive follow-up sequencer
// Notes on behaviour
// - settle limit 3/7/15/31 chips per code
// - phase error 8/15/30/60 deg, tolerance 8/4/2/1 %
// - follow-up control is eight bits at 36h
// - timer preamble failure: bit7 powers down, else stop+interrupt
// - command preamble failure: bit6 powers down, else stop
// - timer wake success, bit5 clear: stop plus interrupt
// - timer wake success: 11 receive+interrupt, 10 preamble
// - timer wake failure: bit3 powers down, else stop+interrupt
// - command wake success: 0X stop+interrupt, 11 receive, 10 preamble
// - command wake failure: bit0 powers down, else stop
// - time constant lives in receive control bits 4:3
// - status top bit set on failure, clear on success
package rfs_pkg;
    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_FOLLOWUP = 8'h36;   // follow-up control
    localparam logic [7:0] ADDR_RXCTRL   = 8'h35;   // receive control
    localparam logic [7:0] ADDR_SIGSTAT  = 8'h37;   // signal monitor result
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_PREA_TF  = 7;  // preamble_timer_fail_action
    localparam int BIT_PREA_CF  = 6;  // preamble_command_fail_action
    localparam int BIT_WAKE_TS  = 4;  // wake_timer_success_action, low bit of two
    localparam int BIT_WAKE_TF  = 3;  // wake_timer_fail_action
    localparam int BIT_WAKE_CS  = 1;  // wake_command_success_action, low bit of two
    localparam int BIT_WAKE_CF  = 0;  // wake_command_fail_action
    localparam int BIT_TC_LO    = 3;  // clk_recovery_time_const low bit
    localparam int BIT_FAIL     = 7;  // failure flag in result register
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_FOLLOWUP = 8'h88;
    localparam logic [7:0] RST_RXCTRL   = 8'h00;
    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    localparam logic [1:0] CODE_RECEIVE  = 2'h3;
    localparam logic [1:0] CODE_PREAMBLE = 2'h2;
    typedef enum logic [2:0] {
        ACT_NONE      = 3'b000,
        ACT_POWERDOWN = 3'b001,
        ACT_STOP      = 3'b010,
        ACT_PREAMBLE  = 3'b011,
        ACT_RECEIVE   = 3'b100
    } rfs_act_e;
    typedef enum logic [1:0] {
        ST_IDLE     = 2'b00,
        ST_WAKE     = 2'b01,
        ST_PREAMBLE = 2'b10,
        ST_RECEIVE  = 2'b11
    } rfs_state_e;
    // settling limit in chips per code
    function automatic logic [4:0] rfs_settle(input logic [1:0] code);
        case (code)
            2'h0: rfs_settle = 5'h03;
            2'h1: rfs_settle = 5'h07;
            2'h2: rfs_settle = 5'h0F;
            default: rfs_settle = 5'h1F;
        endcase
    endfunction : rfs_settle
endpackage : rfs_pkg

// [inc/rfs_if.sv]
// interface: register values handed from the register file to the sequencer
`timescale 1ns/1ps
`default_nettype none
interface rfs_if;
    logic [7:0] followup;   // follow-up control contents
    logic [1:0] timeConst;  // clock-recovery code
    modport regs (output followup, output timeConst);
    modport core (input followup, input timeConst);
endinterface : rfs_if
`default_nettype wire

// [rtl/rfs_regs.sv]
// module: register file of the follow-up sequencer
`timescale 1ns/1ps
`default_nettype none
module rfs_regs
    import rfs_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    input  wire logic       regWrite,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWdata,
    rfs_if.regs             cfg
);
    logic [7:0] followup_q;   // follow-up control
    logic [7:0] followup_d;
    logic [1:0] timeConst_q;  // receive control: only the time-constant field is kept
    logic [1:0] timeConst_d;

    // next values on host writes
    always_comb begin
        followup_d = followup_q;
        timeConst_d = timeConst_q;
        if (regWrite && regAddr == ADDR_FOLLOWUP) begin
            followup_d = regWdata;
        end
        if (regWrite && regAddr == ADDR_RXCTRL) begin
            timeConst_d = regWdata[BIT_TC_LO +: 2];
        end
    end

    // storage
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            followup_q <= RST_FOLLOWUP;
            timeConst_q <= RST_RXCTRL[BIT_TC_LO +: 2];
        end else begin
            followup_q <= followup_d;
            timeConst_q <= timeConst_d;
        end
    end

    assign cfg.followup  = followup_q;
    assign cfg.timeConst = timeConst_q;

    rst_val_a: assert property (@(posedge sys_clk)
        $rose(arst_n) |-> followup_q == RST_FOLLOWUP)
        else $error("follow-up reset value wrong");
endmodule : rfs_regs
`default_nettype wire

// [rtl/rfs_sequencer.sv]
// module: top of the receive follow-up sequencer
`timescale 1ns/1ps
`default_nettype none
module rfs_sequencer
    import rfs_pkg::*;
(
    input  wire logic       sys_clk,        // 25 MHz digital clock
    input  wire logic       arst_n,         // async reset, low
    input  wire logic       regWrite,       // host write strobe
    input  wire logic       regRead,        // host read strobe
    input  wire logic [7:0] regAddr,        // host register address
    input  wire logic [7:0] regWdata,       // host write data
    output logic      [7:0] regRdata,       // host read data
    input  wire logic       wakeStartTimer, // polling timer starts wake search
    input  wire logic       wakeStartCmd,   // host command starts wake search
    input  wire logic       preaStartCmd,   // host command starts preamble detection
    input  wire logic       opDone,         // current search or detection finished
    input  wire logic       opFailed,       // qualifies opDone: failed
    input  wire logic       chipTick,       // one pulse per recovered chip
    output logic            wakeSearchOn,   // wake search active
    output logic            preambleOn,     // preamble detection active
    output logic            receiveOn,      // data reception active
    output logic            powerDown,      // power-down request pulse
    output logic            nmiPulse,       // non-maskable interrupt pulse
    output logic      [1:0] clkRecoveryTimeConst, // selected code
    output logic      [4:0] settleLimit,    // settle limit in chips
    output logic            clkRecoverySettled    // loop allowed to be settled
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    rfs_if cfg ();

    rfs_regs u_regs (
        .sys_clk  (sys_clk),
        .arst_n   (arst_n),
        .regWrite (regWrite),
        .regAddr  (regAddr),
        .regWdata (regWdata),
        .cfg      (cfg)
    );

    // ------------------------------------------------------------
    // operation state
    // ------------------------------------------------------------
    rfs_state_e state_q;      // what the receiver does now
    rfs_state_e state_d;
    logic       byTimer_q;    // operation launched by polling timer
    logic       byTimer_d;
    logic       failed_q;     // result of last operation
    logic       failed_d;
    logic       nmi_q;        // interrupt pulse register
    logic       nmi_d;
    logic       pd_q;         // power-down pulse register
    logic       pd_d;
    logic [4:0] settleCnt_q;  // chips since a search or detection started
    logic [4:0] settleCnt_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    rfs_act_e   act;          // chosen follow-up action
    logic       nmiReq;       // action calls for interrupt

    // follow-up decision for a finished operation
    always_comb begin
        act    = ACT_NONE;
        nmiReq = 1'b0;
        if (opDone && state_q == ST_PREAMBLE && opFailed) begin
            if (byTimer_q) begin
                act    = cfg.followup[BIT_PREA_TF] ? ACT_POWERDOWN : ACT_STOP;
                nmiReq = !cfg.followup[BIT_PREA_TF];
            end else begin
                act = cfg.followup[BIT_PREA_CF] ? ACT_POWERDOWN : ACT_STOP;
            end
        end else if (opDone && state_q == ST_PREAMBLE) begin
            act = ACT_RECEIVE;
        end else if (opDone && state_q == ST_WAKE && opFailed) begin
            if (byTimer_q) begin
                act    = cfg.followup[BIT_WAKE_TF] ? ACT_POWERDOWN : ACT_STOP;
                nmiReq = !cfg.followup[BIT_WAKE_TF];
            end else begin
                act = cfg.followup[BIT_WAKE_CF] ? ACT_POWERDOWN : ACT_STOP;
            end
        end else if (opDone && state_q == ST_WAKE) begin
            if (byTimer_q) begin
                case (cfg.followup[BIT_WAKE_TS +: 2])
                    CODE_RECEIVE: begin
                        act    = ACT_RECEIVE;
                        nmiReq = 1'b1;
                    end
                    CODE_PREAMBLE: act = ACT_PREAMBLE;
                    default: begin
                        act    = ACT_STOP;
                        nmiReq = 1'b1;
                    end
                endcase
            end else begin
                case (cfg.followup[BIT_WAKE_CS +: 2])
                    CODE_RECEIVE:  act = ACT_RECEIVE;
                    CODE_PREAMBLE: act = ACT_PREAMBLE;
                    default: begin
                        act    = ACT_STOP;
                        nmiReq = 1'b1;
                    end
                endcase
            end
        end
    end

    // next state, origin, result, pulses
    always_comb begin
        state_d     = state_q;
        byTimer_d   = byTimer_q;
        failed_d    = failed_q;
        nmi_d       = nmiReq;
        pd_d        = (act == ACT_POWERDOWN);
        settleCnt_d = settleCnt_q;
        if (chipTick && settleCnt_q != 5'h1F) begin
            settleCnt_d = settleCnt_q + 5'h01;
        end
        if (opDone && (state_q == ST_WAKE || state_q == ST_PREAMBLE)) begin
            failed_d = opFailed;
        end
        case (act)
            ACT_POWERDOWN, ACT_STOP: state_d = ST_IDLE;
            ACT_PREAMBLE: begin
                state_d     = ST_PREAMBLE;   // origin kept for this chain
                settleCnt_d = 5'h00;
            end
            ACT_RECEIVE:  state_d = ST_RECEIVE;
            default: begin
                // new launches only from idle
                if (state_q == ST_IDLE && wakeStartTimer) begin
                    state_d     = ST_WAKE;
                    byTimer_d   = 1'b1;
                    settleCnt_d = 5'h00;
                end else if (state_q == ST_IDLE && wakeStartCmd) begin
                    state_d     = ST_WAKE;
                    byTimer_d   = 1'b0;
                    settleCnt_d = 5'h00;
                end else if (state_q == ST_IDLE && preaStartCmd) begin
                    state_d     = ST_PREAMBLE;
                    byTimer_d   = 1'b0;
                    settleCnt_d = 5'h00;
                end
            end
        endcase
    end

    // read data mux
    always_comb begin
        rdata_d = rdata_q;
        if (regRead) begin
            case (regAddr)
                ADDR_FOLLOWUP: rdata_d = cfg.followup;
                ADDR_RXCTRL:   rdata_d = {3'h0, cfg.timeConst, 3'h0};
                ADDR_SIGSTAT:  rdata_d = {failed_q, 7'h00};
                default:       rdata_d = 8'h00;
            endcase
        end
    end

    // state registers
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q     <= ST_IDLE;
            byTimer_q   <= 1'b0;
            failed_q    <= 1'b0;
            nmi_q       <= 1'b0;
            pd_q        <= 1'b0;
            settleCnt_q <= 5'h00;
            rdata_q     <= 8'h00;
        end else begin
            state_q     <= state_d;
            byTimer_q   <= byTimer_d;
            failed_q    <= failed_d;
            nmi_q       <= nmi_d;
            pd_q        <= pd_d;
            settleCnt_q <= settleCnt_d;
            rdata_q     <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign wakeSearchOn         = (state_q == ST_WAKE);
    assign preambleOn           = (state_q == ST_PREAMBLE);
    assign receiveOn            = (state_q == ST_RECEIVE);
    assign powerDown            = pd_q;
    assign nmiPulse             = nmi_q;
    assign regRdata             = rdata_q;
    assign clkRecoveryTimeConst = cfg.timeConst;
    assign settleLimit          = rfs_settle(cfg.timeConst);
    assign clkRecoverySettled   = (settleCnt_q >= rfs_settle(cfg.timeConst));

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence timerPreaFail;
        opDone && opFailed && state_q == ST_PREAMBLE && byTimer_q;
    endsequence

    prea_timer_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        timerPreaFail |=> (powerDown == $past(cfg.followup[7])) && (nmiPulse != powerDown))
        else $error("timer preamble failure action wrong");
    prea_cmd_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        opDone && opFailed && state_q == ST_PREAMBLE && !byTimer_q
        |=> !nmiPulse && state_q == ST_IDLE && powerDown == $past(cfg.followup[6]))
        else $error("command preamble failure action wrong");
    wake_ts_stop_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        opDone && !opFailed && state_q == ST_WAKE && byTimer_q && !cfg.followup[5]
        |=> nmiPulse && state_q == ST_IDLE)
        else $error("timer wake stop without interrupt");
    wake_ts_go_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        opDone && !opFailed && state_q == ST_WAKE && byTimer_q && cfg.followup[5]
        |=> (receiveOn && nmiPulse) || (preambleOn && !nmiPulse))
        else $error("timer wake success action wrong");
    wake_tf_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        opDone && opFailed && state_q == ST_WAKE && byTimer_q
        |=> powerDown != nmiPulse)
        else $error("timer wake failure action wrong");
    wake_cs_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        opDone && !opFailed && state_q == ST_WAKE && !byTimer_q
        |=> nmiPulse == !$past(cfg.followup[2]))
        else $error("command wake success interrupt wrong");
    wake_cf_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        opDone && opFailed && state_q == ST_WAKE && !byTimer_q
        |=> !nmiPulse && powerDown == $past(cfg.followup[0]))
        else $error("command wake failure action wrong");
    nmi_pulse_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        nmiPulse |=> !nmiPulse)
        else $error("interrupt longer than one cycle");
    fail_flag_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        opDone && (wakeSearchOn || preambleOn) |=> failed_q == $past(opFailed))
        else $error("failure flag not updated");
    timer_org_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        state_q == ST_IDLE && wakeStartTimer |=> wakeSearchOn && byTimer_q)
        else $error("timer origin not recorded");
    settle_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        {1'b0, settleLimit} == ((6'h04 << clkRecoveryTimeConst) - 6'h01))
        else $error("settle limit wrong");
endmodule : rfs_sequencer
`default_nettype wire

// [verif/rfs_host_model.sv]
// partner model: host controller issuing register accesses and command starts
`timescale 1ns/1ps
`default_nettype none
module rfs_host_model (
    input  wire logic       sys_clk,      // shared digital clock
    output var  logic       regWrite,     // write strobe
    output var  logic       regRead,      // read strobe
    output var  logic [7:0] regAddr,      // register address
    output var  logic [7:0] regWdata,     // write data
    input  wire logic [7:0] regRdata,     // read data from device
    output var  logic       wakeStartCmd, // command wake search
    output var  logic       preaStartCmd  // command preamble detection
);
    // ------------------------------------------------------------
    // idle bus at time zero
    // ------------------------------------------------------------
    initial begin
        regWrite     = 1'b0;
        regRead      = 1'b0;
        regAddr      = 8'hFF;
        regWdata     = 8'h00;
        wakeStartCmd = 1'b0;
        preaStartCmd = 1'b0;
    end
    // one-cycle write; address and data held through the taking edge
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge sys_clk);
        #1;
        regAddr  = addr;
        regWdata = data;
        regWrite = 1'b1;
        @(posedge sys_clk);
        #1;
        regWrite = 1'b0;
        regWdata = ~data; // released data no longer shows the old value
    endtask : wr
    // one-cycle read; registered data taken after the next edge
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(posedge sys_clk);
        #1;
        regAddr = addr;
        regRead = 1'b1;
        @(posedge sys_clk);
        #1;
        regRead = 1'b0;
        data    = regRdata;
    endtask : rd
    // command start pulse: preamble detection or wake search
    task automatic cmd(input logic pre);
        @(posedge sys_clk);
        #1;
        preaStartCmd = pre;
        wakeStartCmd = ~pre;
        @(posedge sys_clk);
        #1;
        preaStartCmd = 1'b0;
        wakeStartCmd = 1'b0;
    endtask : cmd
endmodule : rfs_host_model
`default_nettype wire

// [verif/tb_top.sv]
// testbench: follow-up sequencer driven through registers and event inputs
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import rfs_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic       sys_clk, arst_n, regWrite, regRead;        // clock, reset, strobes
    logic [7:0] regAddr, regWdata, regRdata, rdv, fu;      // bus and scratch
    logic       wakeStartTimer, wakeStartCmd, preaStartCmd; // start events
    logic       opDone, opFailed, chipTick, fail, tmr;     // end events
    logic       wakeSearchOn, preambleOn, receiveOn, powerDown, nmiPulse;
    logic [1:0] clkRecoveryTimeConst;                      // selected code
    logic [4:0] settleLimit, stateVec;                     // limit, outcome view
    logic       clkRecoverySettled;                        // settled level
    int         n_fail, checks_done, seed, kind;           // bookkeeping
    assign stateVec = {powerDown, nmiPulse, wakeSearchOn, preambleOn, receiveOn};
    // ------------------------------------------------------------
    // clock and instances
    // ------------------------------------------------------------
    initial sys_clk = 1'b0;
    always #20 sys_clk = ~sys_clk;
    rfs_host_model host (.sys_clk(sys_clk), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
        .wakeStartCmd(wakeStartCmd), .preaStartCmd(preaStartCmd));
    rfs_sequencer dut (.sys_clk(sys_clk), .arst_n(arst_n), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
        .wakeStartTimer(wakeStartTimer), .wakeStartCmd(wakeStartCmd),
        .preaStartCmd(preaStartCmd), .opDone(opDone), .opFailed(opFailed),
        .chipTick(chipTick), .wakeSearchOn(wakeSearchOn), .preambleOn(preambleOn),
        .receiveOn(receiveOn), .powerDown(powerDown), .nmiPulse(nmiPulse),
        .clkRecoveryTimeConst(clkRecoveryTimeConst), .settleLimit(settleLimit),
        .clkRecoverySettled(clkRecoverySettled));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // expected {powerDown, nmi, wake, preamble, receive} after an operation ends
    function automatic logic [4:0] outcome(input logic [7:0] f, input logic t,
                                           input logic pre, input logic bad);
        logic [4:0] r;
        if (pre && !bad) r = 5'h01;
        else if (pre) r = t ? (f[7] ? 5'h10 : 5'h08) : (f[6] ? 5'h10 : 5'h00);
        else if (bad) r = t ? (f[3] ? 5'h10 : 5'h08) : (f[0] ? 5'h10 : 5'h00);
        else if (t) r = !f[5] ? 5'h08 : (f[4] ? 5'h09 : 5'h02);
        else r = !f[2] ? 5'h08 : (f[1] ? 5'h01 : 5'h02);
        return r;
    endfunction : outcome
    // compare and count
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // verdict and end of run
    task automatic complete_run();
        if (n_fail == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run
    // short asynchronous reset between trials
    task automatic pulse_reset();
        @(posedge sys_clk);
        #1;
        arst_n = 1'b0;
        @(posedge sys_clk);
        #1;
        arst_n = 1'b1;
    endtask : pulse_reset
    // polling timer start pulse
    task automatic timer_start();
        @(posedge sys_clk);
        #1;
        wakeStartTimer = 1'b1;
        @(posedge sys_clk);
        #1;
        wakeStartTimer = 1'b0;
    endtask : timer_start
    // chip pulses, then let the settle flag land
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            #1;
            chipTick = 1'b1;
            @(posedge sys_clk);
            #1;
            chipTick = 1'b0;
        end
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : ticks
    // end of operation, outcome one cycle on, pulses gone the cycle after
    task automatic op_end(input logic bad, input logic [4:0] exp);
        @(posedge sys_clk);
        #1;
        opFailed = bad;
        opDone   = 1'b1;
        @(posedge sys_clk);
        #1;
        opDone   = 1'b0;
        opFailed = ~bad; // qualifier released
        chk("outcome", {3'h0, exp}, {3'h0, stateVec});
        @(posedge sys_clk);
        #1;
        chk("outcome next cycle", {3'h0, exp & 5'h07}, {3'h0, stateVec});
    endtask : op_end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 99;
        n_fail = 0;
        checks_done = 0;
        arst_n = 1'b0;
        {wakeStartTimer, opDone, opFailed, chipTick} = 4'h0;
        repeat (16) @(posedge sys_clk);
        #1;
        arst_n = 1'b1;
        // reset values, read-only status, unmapped place
        host.rd(ADDR_FOLLOWUP, rdv);
        chk("followup reset", RST_FOLLOWUP, rdv);
        host.rd(ADDR_RXCTRL, rdv);
        chk("rxctrl reset", RST_RXCTRL, rdv);
        host.wr(8'h40, 8'hA5);
        host.wr(ADDR_SIGSTAT, 8'hFF);
        host.rd(8'h40, rdv);
        chk("unmapped read", 8'h00, rdv);
        host.rd(ADDR_SIGSTAT, rdv);
        chk("status untouched", 8'h00, rdv);
        host.rd(ADDR_FOLLOWUP, rdv);
        chk("followup after stray writes", RST_FOLLOWUP, rdv);
        // every time-constant code: readback, limit, settling count
        for (int c = 0; c < 4; c++) begin
            pulse_reset();
            host.wr(ADDR_RXCTRL, 8'(c << 3));
            host.rd(ADDR_RXCTRL, rdv);
            chk("rxctrl readback", 8'(c << 3), rdv);
            chk("time const", 8'(c), {6'h00, clkRecoveryTimeConst});
            chk("settle limit", 8'((4 << c) - 1), {3'h0, settleLimit});
            timer_start();
            ticks((4 << c) - 2);
            chk("settled early", 8'h00, {7'h00, clkRecoverySettled});
            ticks(1);
            chk("settled at limit", 8'h01, {7'h00, clkRecoverySettled});
        end
        // follow-up table: corner values first, then random
        for (int t = 0; t < 60; t++) begin
            kind = t % 5;
            fu   = (t < 5) ? 8'h00 : 8'($random(seed));
            fail = (t < 10) ? 1'((t / 5) % 2) : 1'($random(seed));
            tmr  = (kind == 0 || kind == 3);
            if (kind == 3) fu[5:4] = CODE_PREAMBLE;
            if (kind == 4) fu[2:1] = CODE_PREAMBLE;
            pulse_reset();
            host.wr(ADDR_FOLLOWUP, fu);
            if (kind == 2) host.cmd(1'b1);
            else if (tmr) timer_start();
            else host.cmd(1'b0);
            chk("started", (kind == 2) ? 8'h02 : 8'h04, {3'h0, stateVec});
            if (kind == 2) timer_start();
            else host.cmd(1'b1);
            chk("busy start ignored", (kind == 2) ? 8'h02 : 8'h04, {3'h0, stateVec});
            if (kind >= 3) op_end(1'b0, 5'h02);
            op_end(fail, outcome(fu, tmr, kind >= 2, fail));
            host.rd(ADDR_SIGSTAT, rdv);
            chk("status flag", {fail, 7'h00}, rdv);
        end
        complete_run();
    end
    // hang guard
    initial begin
        repeat (100000) @(posedge sys_clk);
        n_fail++;
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
